// ### hw/smps_cfg.svh
`ifndef SMPS_CFG_SVH
`define SMPS_CFG_SVH
// register byte offsets
`define SMPS_CTRL_OFS 8'h00
`define SMPS_STAT_OFS 8'h04
`define SMPS_CMD_OFS 8'h08
// control register fields
`define SMPS_CTRL_ENTRY_BIT 0
`define SMPS_CTRL_PPDSEL_BIT 1
`define SMPS_CTRL_DETEN_BIT 2
`define SMPS_CTRL_DETSTOP_BIT 3
`define SMPS_CTRL_DBGEN_BIT 4
`define SMPS_CTRL_OSCST_BIT 5
`define SMPS_CTRL_ADASYNC_BIT 6
`define SMPS_CTRL_W 7
`define SMPS_CTRL_RST 7'h00
// command register fields
`define SMPS_CMD_ACK_BIT 0
// status register fields
`define SMPS_STAT_FLAG_BIT 0
`define SMPS_STAT_LATCH_BIT 1
`define SMPS_STAT_MODE_LSB 2
`define SMPS_STAT_REGON_BIT 5
`define SMPS_STAT_W 6
// entry sequencing: cycles allowed for pins to be captured before stop
`define SMPS_LATCH_NS 40
`define SMPS_CLK_NS 20
`define SMPS_LATCH_CYC ((`SMPS_LATCH_NS + `SMPS_CLK_NS - 1) / `SMPS_CLK_NS)
`endif

// ### hw/smps_pkg.sv
package smps_pkg;
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        SMPS_RUN = 4'h1,
        SMPS_LATCH = 4'h2,
        SMPS_STOP3 = 4'h4,
        SMPS_STOP2 = 4'h8
    } smps_state_t;
endpackage : smps_pkg

// ### hw/smps_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// two-flop synchroniser for a pin level
// ****************************************
module smps_sync
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // level in and out
    input wire logic d,
    output logic q
);
    logic meta_r; // first stage, read only by q
    // both stages stall with the clock enable
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end
        else if (ce)
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : smps_sync
`default_nettype wire

// ### hw/smps_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "smps_cfg.svh"
// Functional notes
// - detector in stop keeps regulator active
// - stop2 request with detector goes stop3
// - stop3 with detector, debug off: clockgen off, pins held
// - stop entry halts all peripheral clocks
// - debug enable keeps debug clock running
// - stop3 holds pins by retained logic
// - stop2 captures pin states before stopping
// - stop3 retains ram and registers
// - stop2 wake resets registers, keeps ram
// - stop3 clockgen standby, oscillator optional
// - stop2 clockgen off, oscillator off
// - timers halted; reset after stop2 wake
// - converter standby unless async clock in stop3
// - converter reset after stop2 wake
// - serial modules halted; reset after stop2
// - regulator standby unless detector or debug
// - stop with entry disabled forces reset
// - select bit: 1 stop2, 0 stop3
// - stop2 wake sets flag until ack
// - stop2 request with debug goes stop3
module smps_seq
(
    // ahb-lite clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // core side
    input wire logic stop_req,
    output logic illegal_op_reset,
    // wake-up pins and periodic wake-up (asynchronous)
    input wire logic wake_pin,
    input wire logic periodic_wakeup_interrupt,
    // power and clock controls
    output logic periph_clk_en,
    output logic debug_clk_en,
    output logic regulator_active,
    output logic clkgen_off,
    output logic clkgen_standby,
    output logic osc_run,
    output logic converter_standby,
    output logic pin_latch_capture,
    output logic pin_latch_hold,
    output logic ram_retain,
    output logic stop2_module_reset
);
    // ****************************************
    // register file state
    // ****************************************
    logic [`SMPS_CTRL_W-1:0] ctrl_r; // software controls
    logic flag_r; // partial power down flag
    logic latch_r; // pin latches closed
    logic [31:0] hrdata_r;
    logic wr_pend_r; // write data phase pending
    logic [7:0] waddr_r;
    smps_pkg::smps_state_t state_r; // one-hot sequencer state
    smps_pkg::smps_state_t state_nxt;
    logic [1:0] cnt_r; // latch capture cycles
    logic modrst_r;
    logic [31:0] rd_mux;
    // wake level after two flops
    logic wake_pin_s;
    logic tick_s;
    logic wake;
    // both sources come from outside this clock, so each gets two flops
    smps_sync u_sync_pin (.hclk(hclk), .hresetn(hresetn), .ce(ce), .d(wake_pin), .q(wake_pin_s));
    smps_sync u_sync_tick
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .d(periodic_wakeup_interrupt),
        .q(tick_s)
    );
    assign wake = wake_pin_s | tick_s;
    // ****************************************
    // named control fields
    // ****************************************
    wire stop_entry_enable = ctrl_r[`SMPS_CTRL_ENTRY_BIT];
    wire partial_power_down_select = ctrl_r[`SMPS_CTRL_PPDSEL_BIT];
    wire low_voltage_detect_enable = ctrl_r[`SMPS_CTRL_DETEN_BIT];
    wire low_voltage_stop_enable = ctrl_r[`SMPS_CTRL_DETSTOP_BIT];
    wire debug_mode_enable = ctrl_r[`SMPS_CTRL_DBGEN_BIT];
    wire oscillator_run_in_stop = ctrl_r[`SMPS_CTRL_OSCST_BIT];
    wire converter_async_clock = ctrl_r[`SMPS_CTRL_ADASYNC_BIT];
    // detector armed for stop needs both enables
    wire detect_in_stop = low_voltage_detect_enable & low_voltage_stop_enable;
    // overrides fold a stop2 request into stop3
    wire go_stop2 = partial_power_down_select & ~detect_in_stop & ~debug_mode_enable;
    wire in_stop = state_r != smps_pkg::SMPS_RUN;
    wire in_stop2 = state_r == smps_pkg::SMPS_STOP2;
    wire in_stop3 = state_r == smps_pkg::SMPS_STOP3;
    // ****************************************
    // ahb-lite decode
    // ****************************************
    wire addr_ph = hsel & hready & htrans[1];
    wire rd_ph = addr_ph & ~hwrite;
    wire wr_ph = addr_ph & hwrite;
    wire ack_wr = wr_pend_r & (waddr_r == `SMPS_CMD_OFS) & hwdata[`SMPS_CMD_ACK_BIT];
    wire ctrl_wr = wr_pend_r & (waddr_r == `SMPS_CTRL_OFS);
    // always zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    // read mux; unmapped reads as zero
    assign rd_mux = (haddr == `SMPS_CTRL_OFS) ? {25'h0000000, ctrl_r} :
                    (haddr == `SMPS_STAT_OFS) ?
                    {26'h0000000, regulator_active, in_stop2 ? 3'h2 :
                     (in_stop3 ? 3'h3 : 3'h0), latch_r, flag_r} :
                    32'h00000000;
    // ****************************************
    // bus registers
    // ****************************************
    // capture write address, register read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            waddr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end
        else if (ce)
        begin
            wr_pend_r <= wr_ph;
            waddr_r <= haddr;
            if (rd_ph)
            begin
                hrdata_r <= rd_mux;
            end
        end
    end
    // control register survives stop3 but not stop2 wake
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r <= `SMPS_CTRL_RST;
        end
        else if (ce)
        begin
            if (in_stop2 && wake)
            begin
                ctrl_r <= `SMPS_CTRL_RST;
            end
            else if (ctrl_wr)
            begin
                ctrl_r <= hwdata[`SMPS_CTRL_W-1:0];
            end
        end
    end
    // ****************************************
    // stop sequencer
    // ****************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            smps_pkg::SMPS_RUN:
            begin
                // disabled entry never leaves run
                if (stop_req && stop_entry_enable)
                begin
                    state_nxt = go_stop2 ? smps_pkg::SMPS_LATCH : smps_pkg::SMPS_STOP3;
                end
            end
            smps_pkg::SMPS_LATCH:
            begin
                // pins captured before stop2 proper
                if (cnt_r == 2'(`SMPS_LATCH_CYC - 1))
                begin
                    state_nxt = smps_pkg::SMPS_STOP2;
                end
            end
            smps_pkg::SMPS_STOP3:
            begin
                if (wake)
                begin
                    state_nxt = smps_pkg::SMPS_RUN;
                end
            end
            smps_pkg::SMPS_STOP2:
            begin
                if (wake)
                begin
                    state_nxt = smps_pkg::SMPS_RUN;
                end
            end
            default:
            begin
                // an illegal code falls back to run rather than hanging
                state_nxt = smps_pkg::SMPS_RUN;
            end
        endcase
    end
    // state, capture counter and flags
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r <= smps_pkg::SMPS_RUN;
            cnt_r <= 2'h0;
            flag_r <= 1'b0;
            latch_r <= 1'b0;
            modrst_r <= 1'b0;
            illegal_op_reset <= 1'b0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            cnt_r <= (state_r == smps_pkg::SMPS_LATCH) ? cnt_r + 2'h1 : 2'h0;
            illegal_op_reset <= !in_stop && stop_req && !stop_entry_enable;
            modrst_r <= in_stop2 && wake;
            // set wins over acknowledge
            if (in_stop2 && wake)
            begin
                flag_r <= 1'b1;
            end
            else if (ack_wr)
            begin
                flag_r <= 1'b0;
            end
            // latches close on capture, open only on acknowledge
            if (state_r == smps_pkg::SMPS_LATCH)
            begin
                latch_r <= 1'b1;
            end
            else if (ack_wr && !in_stop2)
            begin
                latch_r <= 1'b0;
            end
        end
    end
    // ****************************************
    // power and clock outputs
    // ****************************************
    // any stop halts every peripheral clock
    assign periph_clk_en = ~in_stop;
    // debug clock kept only by its enable
    assign debug_clk_en = ~in_stop | debug_mode_enable;
    // full regulation in run or with an override
    assign regulator_active = ~in_stop | detect_in_stop | debug_mode_enable;
    // clockgen off in stop2 and with the detector armed and debug off in stop3
    assign clkgen_off = in_stop2 | (in_stop3 & detect_in_stop & ~debug_mode_enable);
    assign clkgen_standby = in_stop3 & ~clkgen_off;
    // oscillator may run only in stop3
    assign osc_run = ~in_stop | (in_stop3 & oscillator_run_in_stop);
    // async clock keeps conversions alive in stop3
    assign converter_standby = in_stop & ~(in_stop3 & converter_async_clock);
    assign pin_latch_capture = state_r == smps_pkg::SMPS_LATCH;
    // stop3 pins held by frozen logic, no latch
    assign pin_latch_hold = latch_r;
    assign ram_retain = 1'b1;
    assign stop2_module_reset = modrst_r;
endmodule : smps_seq
`default_nettype wire

// ### sim/smps_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// stop sequencer port checks
// ****************************************
module smps_monitor
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // core side
    input wire logic stop_req,
    input wire logic illegal_op_reset,
    // power and clock controls
    input wire logic periph_clk_en,
    input wire logic debug_clk_en,
    input wire logic regulator_active,
    input wire logic clkgen_off,
    input wire logic clkgen_standby,
    input wire logic osc_run,
    input wire logic converter_standby,
    input wire logic pin_latch_capture,
    input wire logic pin_latch_hold,
    input wire logic ram_retain,
    input wire logic stop2_module_reset
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_halt; (clkgen_off || clkgen_standby) |-> !periph_clk_en; endproperty
    a_halt: assert property (p_halt) else $error("peripheral clock runs in stop");
    property p_capt; $rose(pin_latch_hold) |-> $past(pin_latch_capture); endproperty
    a_capt: assert property (p_capt) else $error("pins held without capture");
    property p_osc2; (pin_latch_hold && clkgen_off) |-> !osc_run; endproperty
    a_osc2: assert property (p_osc2) else $error("oscillator runs in deep stop");
    property p_dbg; (debug_clk_en && !periph_clk_en) |-> regulator_active; endproperty
    a_dbg: assert property (p_dbg) else $error("regulator idle with debug on");
    property p_sel; pin_latch_capture |-> !regulator_active && !debug_clk_en; endproperty
    a_sel: assert property (p_sel) else $error("deep stop despite override");
    property p_rst2; stop2_module_reset |-> pin_latch_hold; endproperty
    a_rst2: assert property (p_rst2) else $error("latches open at deep wake");
    property p_ill; illegal_op_reset |-> $past(stop_req) && periph_clk_en; endproperty
    a_ill: assert property (p_ill) else $error("reset without stop request");
    property p_ram; ram_retain; endproperty
    a_ram: assert property (p_ram) else $error("ram not retained");
    property p_stby; clkgen_standby |-> !clkgen_off && !pin_latch_capture; endproperty
    a_stby: assert property (p_stby) else $error("light stop state mixed");
    property p_adc; converter_standby |-> !periph_clk_en; endproperty
    a_adc: assert property (p_adc) else $error("converter idle in run");
endmodule : smps_monitor
bind smps_seq smps_monitor mon_u (.*);
`default_nettype wire

// ### sim/smps_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// core and wake sources stand-in
// ****************************************
module smps_core_model
(
    // clock
    input wire logic hclk,
    // towards the sequencer
    output logic stop_req,
    output logic wake_pin,
    output logic periodic_wakeup_interrupt
);
    // all idle from time zero
    initial {stop_req, wake_pin, periodic_wakeup_interrupt} = 3'h0;
    // stop instruction lasts one cycle, like a real core
    task automatic stop_insn();
        @(posedge hclk) stop_req <= 1'h1;
        @(posedge hclk) stop_req <= 1'h0;
    endtask : stop_insn
    // level wake source, held by caller until run resumes
    task automatic wake(input logic pin, input logic lvl);
        @(posedge hclk);
        if (pin)
            wake_pin <= lvl;
        else
            periodic_wakeup_interrupt <= lvl;
    endtask : wake
endmodule : smps_core_model
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "smps_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
// ****************************************
// stop sequencer bench
// ****************************************
module testbench;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, stop_req, illegal_op_reset, wake_pin, pwi, s2rst;
    logic periph_clk_en, debug_clk_en, regulator_active, clkgen_off, clkgen_standby;
    logic osc_run, converter_standby, pin_latch_capture, pin_latch_hold, ram_retain;
    int n_fail = 0;
    int checked = 0;
    int n_s2rst = 0;
    always #10 hclk = ~hclk;
    // count deep-wake reset pulses, they last one cycle
    always @(posedge hclk) if (s2rst === 1'h1) n_s2rst++;
    smps_seq dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stop_req(stop_req),
        .illegal_op_reset(illegal_op_reset), .wake_pin(wake_pin),
        .periodic_wakeup_interrupt(pwi), .periph_clk_en(periph_clk_en),
        .debug_clk_en(debug_clk_en), .regulator_active(regulator_active),
        .clkgen_off(clkgen_off), .clkgen_standby(clkgen_standby), .osc_run(osc_run),
        .converter_standby(converter_standby), .pin_latch_capture(pin_latch_capture),
        .pin_latch_hold(pin_latch_hold), .ram_retain(ram_retain), .stop2_module_reset(s2rst));
    smps_core_model core_u (.hclk(hclk), .stop_req(stop_req), .wake_pin(wake_pin),
        .periodic_wakeup_interrupt(pwi));
    // bounded wait for a level, sampled at the edge
    task automatic wait_hi(ref logic s);
        int i;
        i = 0;
        do
        begin
            @(posedge hclk);
            i++;
            if (i > 40)
            begin
                n_fail++;
                conclude();
            end
        end while (s !== 1'h1);
    endtask : wait_hi
    // one single ahb-lite word transfer, read data into rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_hi(hreadyout);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_hi(hreadyout);
        rd = hrdata;
    endtask : bus
    // program control, issue stop, let the entry walk finish
    task automatic enter(input logic [31:0] c);
        bus(1'h1, `SMPS_CTRL_OFS, c);
        core_u.stop_insn();
        repeat (4) @(posedge hclk);
        #1;
    endtask : enter
    // raise a wake source until run resumes
    task automatic leave(input logic pin);
        core_u.wake(pin, 1'h1);
        wait_hi(periph_clk_en);
        core_u.wake(pin, 1'h0);
        repeat (3) @(posedge hclk);
    endtask : leave
    task automatic t_illegal();
        bus(1'h0, `SMPS_CTRL_OFS, 32'h0);
        `CHK(rd, 32'h0);
        `CHK(hresp, 1'h0);
        core_u.stop_insn();
        wait_hi(illegal_op_reset);
        #1;
        `CHK(periph_clk_en, 1'h1);
        $display("illegal stop done");
    endtask : t_illegal
    task automatic t_stop3();
        enter(32'h61);
        `CHK({periph_clk_en, clkgen_standby, osc_run, converter_standby, regulator_active, pin_latch_hold}, 6'h18);
        leave(1'h0);
        bus(1'h0, `SMPS_CTRL_OFS, 32'h0);
        `CHK(rd, 32'h61);
        $display("light stop done");
    endtask : t_stop3
    task automatic t_stop2();
        int n0;
        enter(32'h23);
        `CHK({periph_clk_en, clkgen_off, osc_run, converter_standby, regulator_active, pin_latch_hold}, 6'h15);
        n0 = n_s2rst;
        leave(1'h1);
        `CHK(n_s2rst, n0 + 1);
        bus(1'h0, `SMPS_STAT_OFS, 32'h0);
        `CHK(rd, 32'h23);
        bus(1'h0, `SMPS_CTRL_OFS, 32'h0);
        `CHK(rd, 32'h0);
        bus(1'h1, `SMPS_CMD_OFS, 32'h1);
        bus(1'h0, `SMPS_STAT_OFS, 32'h0);
        `CHK(rd, 32'h20);
        `CHK(pin_latch_hold, 1'h0);
        $display("deep stop done");
    endtask : t_stop2
    task automatic t_detect();
        enter(32'h0F);
        `CHK({periph_clk_en, clkgen_off, regulator_active, pin_latch_hold}, 4'h6);
        bus(1'h0, `SMPS_STAT_OFS, 32'h0);
        `CHK(rd, 32'h2C);
        leave(1'h0);
        $display("detector stop done");
    endtask : t_detect
    task automatic t_dbg();
        int n0;
        n0 = n_s2rst;
        enter(32'h13);
        `CHK({periph_clk_en, debug_clk_en, regulator_active, pin_latch_hold}, 4'h6);
        leave(1'h1);
        `CHK(n_s2rst, n0);
        $display("debug stop done");
    endtask : t_dbg
    // verdict and end of run
    task automatic conclude();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        t_illegal();
        t_stop3();
        t_stop2();
        t_detect();
        t_dbg();
        conclude();
    end
endmodule : testbench
`default_nettype wire
